// File: rtl/pmr_bank.sv
// pmr_bank: management register bank of the transceiver, device end.
// assumes the controller issues one access at a time on the pmr_if channel.
//
// Behaviour
// - read-only bits ignore writes
// - write-only bits read back undefined
// - writing one clears, zero leaves bit
// - any write clears the bit
// - read returns then clears, writes ignored
// - latched status held until register read
// - self-clearing bits drop back alone
// - latched-high stays until read and cause gone
// - marked bits survive software reset
// - only the soft-reset bit spares them
// - controller writes zero to reserved bits
// - read-write bits return held value
// - each index selects at most one register
// - advanced registers read via address, data ports
// - decode 0-10, 15-21, 27, 29-31
// - controller avoids unsupported indices
// - event flags at 29, mask at 30
// - every register sixteen bits wide
// - standard management register organisation
// - soft-reset bit clears when reset completes
`timescale 1ns/1ps
module pmr_bank #(
  parameter logic [15:0] ID_HIGH  = 16'h1234, // arbitrary identifier value
  parameter logic [15:0] ID_LOW   = 16'h5670, // arbitrary identifier value
  parameter int          ADV_REGS = 16
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  pmr_if.device            mgmt,
  input  wire logic        link_up_i,
  input  wire logic        remote_fault_i,
  input  wire logic        jabber_i,
  input  wire logic [15:0] status_bits_i,
  input  wire logic [15:0] partner_i,
  input  wire logic [15:0] event_i,
  input  wire logic        neg_done_i,
  input  wire logic [15:0] adv_data_i [ADV_REGS],
  output logic [15:0]      control_o,
  output logic             soft_reset_o,
  output logic             restart_neg_o,
  output logic [15:0]      event_mask_o
);
  // ==========================================================================
  // decode
  wire logic       wr       = mgmt.req & mgmt.we;
  wire logic       rd       = mgmt.req & ~mgmt.we;
  wire logic [4:0] idx      = mgmt.idx;
  wire logic       hit_lo   = (idx <= pmr_pkg::IDX_LF_STATUS);
  wire logic       hit_mid  = (idx >= pmr_pkg::IDX_EXTENDED_STATUS) &&
                              (idx <= pmr_pkg::IDX_INDIRECT_READ);
  wire logic       hit_hi   = (idx == pmr_pkg::IDX_INDICATIONS) ||
                              (idx >= pmr_pkg::IDX_EVENT_FLAGS);
  wire logic       mapped   = hit_lo | hit_mid | hit_hi;
  wire logic       wr_ok    = wr & mapped;
  wire logic       rd_ok    = rd & mapped;

  wire logic wr_ctl  = wr_ok && (idx == pmr_pkg::IDX_BASIC_CONTROL);
  wire logic rd_stat = rd_ok && (idx == pmr_pkg::IDX_BASIC_STATUS);
  wire logic rd_flag = rd_ok && (idx == pmr_pkg::IDX_EVENT_FLAGS);
  wire logic wr_ind  = wr_ok && (idx == pmr_pkg::IDX_INDICATIONS);

  // ==========================================================================
  // storage
  logic [15:0] control_reg, advertise_reg, next_tx_reg, lf_ctl_reg, link_ctl_reg;
  logic [15:0] ls_ctl_reg, ls_modes_reg, ext_mode_reg, adv_addr_reg, ind_reg;
  logic [15:0] special_reg, mask_reg, flags_reg;
  logic        link_ll_reg, fault_lh_reg, jab_lh_reg, jab_read_reg;
  logic [7:0]  sr_cnt_reg;
  logic        ack_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic        restart_reg;

  wire logic soft_busy = control_reg[pmr_pkg::BIT_SOFT_RESET];
  wire logic sr_done   = soft_busy && (sr_cnt_reg == 8'(pmr_pkg::SOFT_RESET_CYCLES - 1));
  wire logic sr_start  = wr_ctl && mgmt.wdata[pmr_pkg::BIT_SOFT_RESET];

  // software-reset value: marked bits keep state, others return to defaults
  wire logic [15:0] ctl_after_sr = (control_reg & pmr_pkg::CONTROL_KEEP_ACROSS_SOFT_RESET_MASK) |
                                   (pmr_pkg::RST_CONTROL & ~pmr_pkg::CONTROL_KEEP_ACROSS_SOFT_RESET_MASK);

  // control register: rw fields, self-clearing reset and restart bits
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      control_reg <= pmr_pkg::RST_CONTROL;   // hardware reset reinits all
      sr_cnt_reg  <= 8'h00;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_ctl && mgmt.wdata[pmr_pkg::BIT_RESTART_NEG] && !soft_busy;
      if (sr_done) begin
        control_reg <= ctl_after_sr;
        sr_cnt_reg  <= 8'h00;
      end else if (soft_busy) begin
        sr_cnt_reg  <= sr_cnt_reg + 8'h01;
      end else if (wr_ctl) begin
        // zero to self-clearing bit has no effect; read-only bits untouched
        control_reg <= (mgmt.wdata & pmr_pkg::CONTROL_RW_MASK) |
                       (sr_start ? 16'h8000 : 16'h0000);
      end
    end
  end

  // plain read-write registers; soft reset returns them to defaults
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || sr_done) begin
      advertise_reg <= pmr_pkg::RST_ADVERTISE;
      next_tx_reg   <= pmr_pkg::RST_GENERIC;
      lf_ctl_reg    <= pmr_pkg::RST_GENERIC;
      link_ctl_reg  <= pmr_pkg::RST_GENERIC;
      ls_ctl_reg    <= pmr_pkg::RST_GENERIC;
      ls_modes_reg  <= pmr_pkg::RST_GENERIC;
      ext_mode_reg  <= pmr_pkg::RST_GENERIC;
      adv_addr_reg  <= pmr_pkg::RST_GENERIC;
      special_reg   <= pmr_pkg::RST_GENERIC;
      mask_reg      <= pmr_pkg::RST_GENERIC;
    end else if (wr_ok) begin
      unique case (idx)
        pmr_pkg::IDX_NEG_ADVERTISE:     advertise_reg <= mgmt.wdata;
        pmr_pkg::IDX_NEXT_PAGE_TX:      next_tx_reg   <= mgmt.wdata;
        pmr_pkg::IDX_LF_CONTROL:        lf_ctl_reg    <= mgmt.wdata;
        pmr_pkg::IDX_LINK_CONTROL:      link_ctl_reg  <= mgmt.wdata;
        pmr_pkg::IDX_LS_CONTROL_STATUS: ls_ctl_reg    <= mgmt.wdata;
        pmr_pkg::IDX_LS_SPECIAL_MODES:  ls_modes_reg  <= mgmt.wdata;
        pmr_pkg::IDX_EXT_MODE_CONTROL:  ext_mode_reg  <= mgmt.wdata;
        pmr_pkg::IDX_INDIRECT_ADDRESS:  adv_addr_reg  <= mgmt.wdata;
        pmr_pkg::IDX_SPECIAL_CONTROL:   special_reg   <= mgmt.wdata;
        pmr_pkg::IDX_EVENT_MASK:        mask_reg      <= mgmt.wdata;
        default: ;                                // read-only indices; control and indications written elsewhere
      endcase
    end
  end

  // event flags read-to-clear; a new event in the read cycle survives
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || sr_done) begin
      flags_reg <= 16'h0000;
    end else begin
      flags_reg <= (rd_flag ? 16'h0000 : flags_reg) | event_i;
    end
  end

  // indications: bit 0 write-any-clear, bit 1 write-one-clear, set wins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || sr_done) begin
      ind_reg <= 16'h0000;
    end else begin
      ind_reg[15:2] <= wr_ind ? mgmt.wdata[15:2] : ind_reg[15:2];
      ind_reg[pmr_pkg::BIT_TOGGLE_STAT] <= (ind_reg[0] & ~wr_ind) | neg_done_i;
      ind_reg[1] <= (ind_reg[1] & ~(wr_ind & mgmt.wdata[1])) | remote_fault_i;
    end
  end

  // latched status bits of the basic status register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      link_ll_reg  <= 1'b0;
      fault_lh_reg <= 1'b0;
      jab_lh_reg   <= 1'b0;
      jab_read_reg <= 1'b0;
    end else begin
      // low latches until read, then follows the live level
      link_ll_reg  <= rd_stat ? link_up_i : (link_ll_reg & link_up_i);
      fault_lh_reg <= rd_stat ? remote_fault_i : (fault_lh_reg | remote_fault_i);
      // read-only latching-high: after read, falls only once cause is gone
      jab_read_reg <= jab_lh_reg & (jab_read_reg | rd_stat) & jabber_i;
      jab_lh_reg   <= jabber_i | (jab_lh_reg & ~(jab_read_reg | rd_stat));
    end
  end

  // ==========================================================================
  // read mux; unmapped and write-only views return zero
  wire logic [3:0]  adv_sel  = adv_addr_reg[3:0];
  wire logic [15:0] adv_word = (32'(adv_sel) < ADV_REGS) ? adv_data_i[adv_sel] : 16'h0000;
  wire logic [15:0] stat_word = {status_bits_i[15:5], fault_lh_reg, status_bits_i[3],
                                 link_ll_reg, jab_lh_reg, status_bits_i[0]};

  always_comb begin
    rdata_next = 16'h0000;
    unique case (idx)
      pmr_pkg::IDX_BASIC_CONTROL:     rdata_next = control_reg;
      pmr_pkg::IDX_BASIC_STATUS:      rdata_next = stat_word;
      pmr_pkg::IDX_IDENTIFIER_HIGH:   rdata_next = ID_HIGH;
      pmr_pkg::IDX_IDENTIFIER_LOW:    rdata_next = ID_LOW;
      pmr_pkg::IDX_NEG_ADVERTISE:     rdata_next = advertise_reg;
      pmr_pkg::IDX_PARTNER_ABILITY:   rdata_next = partner_i;
      pmr_pkg::IDX_NEXT_PAGE_TX:      rdata_next = next_tx_reg;
      pmr_pkg::IDX_LF_CONTROL:        rdata_next = lf_ctl_reg;
      pmr_pkg::IDX_LINK_CONTROL:      rdata_next = link_ctl_reg;
      pmr_pkg::IDX_LS_CONTROL_STATUS: rdata_next = ls_ctl_reg;
      pmr_pkg::IDX_LS_SPECIAL_MODES:  rdata_next = ls_modes_reg;
      pmr_pkg::IDX_EXT_MODE_CONTROL:  rdata_next = ext_mode_reg;
      pmr_pkg::IDX_INDIRECT_ADDRESS:  rdata_next = adv_addr_reg;
      pmr_pkg::IDX_INDIRECT_READ:     rdata_next = adv_word;
      pmr_pkg::IDX_INDICATIONS:       rdata_next = ind_reg;
      pmr_pkg::IDX_EVENT_FLAGS:       rdata_next = flags_reg;
      pmr_pkg::IDX_EVENT_MASK:        rdata_next = mask_reg;
      pmr_pkg::IDX_SPECIAL_CONTROL:   rdata_next = special_reg;
      default:                        rdata_next = 16'h0000;
    endcase
  end

  // answer one cycle after each request
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg   <= mgmt.req;
      rdata_reg <= rd_ok ? rdata_next : 16'h0000;
    end
  end

  logic [15:0] mask_out_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_out_reg <= 16'h0000;
    end else begin
      mask_out_reg <= mask_reg;
    end
  end

  assign mgmt.ack      = ack_reg;
  assign mgmt.rdata    = rdata_reg;
  assign control_o     = control_reg;
  assign soft_reset_o  = control_reg[pmr_pkg::BIT_SOFT_RESET];
  assign restart_neg_o = restart_reg;
  assign event_mask_o  = mask_out_reg;
endmodule

// File: rtl/pmr_ctl.sv
// pmr_ctl: station management controller end driving the register bank.
// assumes one clock; the user issues one command and waits for done_o.
`timescale 1ns/1ps
module pmr_ctl (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  pmr_if.host              mgmt,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [4:0]  cmd_idx_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic [15:0] cmd_rsvd_mask_i,  // ones mark reserved bits
  output logic             cmd_ready_o,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic             refused_o
);
  pmr_pkg::pmr_ctl_state_t state_reg;
  logic        req_reg, we_reg, done_reg, ready_reg, refused_reg;
  logic [4:0]  idx_reg;
  logic [15:0] wdata_reg, rdata_reg;

  // ==========================================================================
  // supported index set; others are never put on the channel
  wire logic in_lo = (cmd_idx_i <= pmr_pkg::IDX_LF_STATUS);
  wire logic in_md = (cmd_idx_i >= pmr_pkg::IDX_EXTENDED_STATUS) &&
                     (cmd_idx_i <= pmr_pkg::IDX_INDIRECT_READ);
  wire logic in_hi = (cmd_idx_i == pmr_pkg::IDX_INDICATIONS) ||
                     (cmd_idx_i >= pmr_pkg::IDX_EVENT_FLAGS);
  wire logic legal = in_lo | in_md | in_hi;
  wire logic take  = cmd_valid_i && (state_reg == pmr_pkg::PMR_IDLE);

  // command sequencing: one access in flight at a time
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg   <= pmr_pkg::PMR_IDLE;
      req_reg     <= 1'b0;
      we_reg      <= 1'b0;
      idx_reg     <= 5'h00;
      wdata_reg   <= 16'h0000;
      done_reg    <= 1'b0;
      ready_reg   <= 1'b1;
      refused_reg <= 1'b0;
      rdata_reg   <= 16'h0000;
    end else begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      req_reg     <= 1'b0;
      unique case (state_reg)
        pmr_pkg::PMR_IDLE: begin
          if (take && legal) begin
            req_reg   <= 1'b1;
            we_reg    <= cmd_write_i;
            idx_reg   <= cmd_idx_i;
            wdata_reg <= cmd_wdata_i & ~cmd_rsvd_mask_i;
            ready_reg <= 1'b0;
            state_reg <= pmr_pkg::PMR_WAIT;
          end else if (take) begin
            refused_reg <= 1'b1;
          end
        end
        pmr_pkg::PMR_WAIT: begin
          if (mgmt.ack) begin
            done_reg  <= 1'b1;
            rdata_reg <= we_reg ? rdata_reg : mgmt.rdata;
            ready_reg <= 1'b1;
            state_reg <= pmr_pkg::PMR_IDLE;
          end
        end
        default: state_reg <= pmr_pkg::PMR_IDLE;
      endcase
    end
  end

  assign mgmt.req    = req_reg;
  assign mgmt.we     = we_reg;
  assign mgmt.idx    = idx_reg;
  assign mgmt.wdata  = wdata_reg;
  assign cmd_ready_o = ready_reg;
  assign done_o      = done_reg;
  assign rdata_o     = rdata_reg;
  assign refused_o   = refused_reg;
endmodule

// File: rtl/pmr_if.sv
// pmr_if: management access channel between controller and register bank.
// assumes one clock; a request is a one-cycle strobe, the answer comes a cycle later.
`timescale 1ns/1ps
interface pmr_if;
  logic        req;     // one-cycle request strobe
  logic        we;      // 1 write, 0 read
  logic [4:0]  idx;     // decimal register index
  logic [15:0] wdata;
  logic        ack;     // one-cycle answer pulse
  logic [15:0] rdata;

  modport device (input req, we, idx, wdata, output ack, rdata);
  modport host   (output req, we, idx, wdata, input ack, rdata);
endinterface

// File: rtl/pmr_pkg.sv
// pmr_pkg: shared constants for the management register bank and its controller.
// assumes both ends run on one 125 MHz clock with a synchronous reset.
package pmr_pkg;
  // ==========================================================================
  // register indices
  localparam logic [4:0] IDX_BASIC_CONTROL     = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS      = 5'h01;
  localparam logic [4:0] IDX_IDENTIFIER_HIGH   = 5'h02;
  localparam logic [4:0] IDX_IDENTIFIER_LOW    = 5'h03;
  localparam logic [4:0] IDX_NEG_ADVERTISE     = 5'h04;
  localparam logic [4:0] IDX_PARTNER_ABILITY   = 5'h05;
  localparam logic [4:0] IDX_NEG_EXPANSION     = 5'h06;
  localparam logic [4:0] IDX_NEXT_PAGE_TX      = 5'h07;
  localparam logic [4:0] IDX_NEXT_PAGE_RX      = 5'h08;
  localparam logic [4:0] IDX_LF_CONTROL        = 5'h09;
  localparam logic [4:0] IDX_LF_STATUS         = 5'h0a;
  localparam logic [4:0] IDX_EXTENDED_STATUS   = 5'h0f;
  localparam logic [4:0] IDX_LINK_CONTROL      = 5'h10;
  localparam logic [4:0] IDX_LS_CONTROL_STATUS = 5'h11;
  localparam logic [4:0] IDX_LS_SPECIAL_MODES  = 5'h12;
  localparam logic [4:0] IDX_EXT_MODE_CONTROL  = 5'h13;
  localparam logic [4:0] IDX_INDIRECT_ADDRESS  = 5'h14;
  localparam logic [4:0] IDX_INDIRECT_READ     = 5'h15;
  localparam logic [4:0] IDX_INDICATIONS       = 5'h1b;
  localparam logic [4:0] IDX_EVENT_FLAGS       = 5'h1d;
  localparam logic [4:0] IDX_EVENT_MASK        = 5'h1e;
  localparam logic [4:0] IDX_SPECIAL_CONTROL   = 5'h1f;

  // ==========================================================================
  // field positions
  localparam int          BIT_SOFT_RESET   = 15;
  localparam int          BIT_RESTART_NEG  = 9;
  localparam int          BIT_LINK_UP      = 2;  // latching-low link status
  localparam int          BIT_REMOTE_FAULT = 4;  // latching-high fault
  localparam int          BIT_JABBER       = 1;  // latching-high jabber
  localparam int          BIT_TOGGLE_STAT  = 0;  // write-any-clear status in indications
  localparam logic [15:0] CONTROL_RW_MASK  = 16'h7dc0; // bits 14..10, 8..6
  localparam logic [15:0] CONTROL_KEEP_ACROSS_SOFT_RESET_MASK = 16'h0100; // duplex kept over soft reset

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_CONTROL   = 16'h1140;
  localparam logic [15:0] RST_ADVERTISE = 16'h01e1;
  localparam logic [15:0] RST_GENERIC   = 16'h0000;

  // ==========================================================================
  // timing
  localparam int SOFT_RESET_NS     = 80;
  localparam int CLK_PERIOD_NS     = 8;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_CYCLES    = 1;

  // controller states
  typedef enum logic [1:0] {
    PMR_IDLE  = 2'b00,
    PMR_ISSUE = 2'b01,
    PMR_WAIT  = 2'b10
  } pmr_ctl_state_t;
endpackage

// File: sim/pmr_monitor.sv
// pmr_monitor: timing and value checks on the management channel.
// assumes it sees the pmr_if signals as plain inputs on one clock.
`timescale 1ns/1ps
module pmr_monitor #(
  parameter logic [15:0] ID_HIGH = 16'h1234,
  parameter logic [15:0] ID_LOW  = 16'h5670
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        req_i,
  input wire logic        we_i,
  input wire logic [4:0]  idx_i,
  input wire logic [15:0] wdata_i,
  input wire logic        ack_i,
  input wire logic [15:0] rdata_i
);
  // ==========================================================================
  // helper: last mask written; soft reset returns it to default
  logic [15:0] mask_reg;
  wire         rd_w = req_i && !we_i;
  wire         soft_w = req_i && we_i && idx_i == 5'h00 && wdata_i[15];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || soft_w) begin
      mask_reg <= 16'h0000;
    end else if (req_i && we_i && idx_i == 5'h1e) begin
      mask_reg <= wdata_i;
    end
  end

  // ==========================================================================
  // assertions
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (req_i |=> ack_i)
    else $error("ack not one cycle after request");
  a_ack_has_cause: assert property (ack_i |-> $past(req_i))
    else $error("ack without request");
  a_req_single_pulse: assert property (req_i |=> !req_i)
    else $error("request held over two cycles");
  a_write_reads_zero: assert property (req_i && we_i |=> rdata_i == 16'h0000)
    else $error("write answer carries data");
  a_ident_fixed: assert property (rd_w && idx_i inside {5'h02, 5'h03}
    |=> rdata_i == ($past(idx_i[0]) ? ID_LOW : ID_HIGH))
    else $error("identifier value changed");
  a_control_fixed_zero: assert property (rd_w && idx_i == 5'h00
    |=> (rdata_i & 16'h023f) == 16'h0000)
    else $error("control reserved or restart bit reads one");
  a_mask_readback: assert property (rd_w && idx_i == 5'h1e
    |=> rdata_i == $past(mask_reg))
    else $error("mask read differs from written");
  a_idx_supported: assert property (req_i
    |-> idx_i inside {[5'h00:5'h0a], [5'h0f:5'h15], 5'h1b, [5'h1d:5'h1f]})
    else $error("unsupported index on channel");
endmodule

// File: sim/test_phy_mgmt_register_bank.sv
// test_phy_mgmt_register_bank: controller and bank joined, random and corner traffic.
// assumes one command at a time, each ending in done or refused.
`timescale 1ns/1ps
module test_phy_mgmt_register_bank;
  localparam logic [15:0] IDH = 16'h1234; // arbitrary identifier value
  localparam logic [15:0] IDL = 16'h5670; // arbitrary identifier value
  logic        clk_sys_i, rst_i, link_up, fault, jabber, neg_done, cmd_valid, cmd_write;
  logic        soft_o, restart_o, ready_o, done_o, refused_o, saw_soft, saw_restart, hit_ref;
  logic [4:0]  cmd_idx;
  logic [15:0] status, partner, event_v, cmd_wdata, rsvd, control_o, mask_o, rdata_o, rd, c, v;
  logic [15:0] adv [16];
  int          num_errors, cmp_count;

  pmr_if u_pmr_if ();
  pmr_bank #(.ID_HIGH(IDH), .ID_LOW(IDL)) u_pmr_bank (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .mgmt(u_pmr_if.device), .link_up_i(link_up), .remote_fault_i(fault), .jabber_i(jabber),
    .status_bits_i(status), .partner_i(partner), .event_i(event_v), .neg_done_i(neg_done),
    .adv_data_i(adv), .control_o(control_o), .soft_reset_o(soft_o),
    .restart_neg_o(restart_o), .event_mask_o(mask_o));
  pmr_ctl u_pmr_ctl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mgmt(u_pmr_if.host),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_idx_i(cmd_idx),
    .cmd_wdata_i(cmd_wdata), .cmd_rsvd_mask_i(rsvd), .cmd_ready_o(ready_o),
    .done_o(done_o), .rdata_o(rdata_o), .refused_o(refused_o));
  pmr_monitor #(.ID_HIGH(IDH), .ID_LOW(IDL)) u_pmr_monitor (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .req_i(u_pmr_if.req), .we_i(u_pmr_if.we), .idx_i(u_pmr_if.idx),
    .wdata_i(u_pmr_if.wdata), .ack_i(u_pmr_if.ack), .rdata_i(u_pmr_if.rdata));

  // ==========================================================================
  // clock, pulse catchers and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // restart pulses for one cycle and soft reset for ten, so latch them for later comparison
  always @(posedge clk_sys_i) begin
    if (rst_i === 1'b1) begin
      saw_soft    <= 1'b0;
      saw_restart <= 1'b0;
    end else begin
      if (soft_o === 1'b1) saw_soft <= 1'b1;
      if (restart_o === 1'b1) saw_restart <= 1'b1;
    end
  end
  // the run needs some 250 cycles; give it about fifty times that
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  // ==========================================================================
  // tasks
  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one command; trailing step keeps valid from toggling twice in one time step
  task automatic cmd(input logic w, input logic [4:0] ix, input logic [15:0] wd);
    int   n;
    logic ok;
    n = 0;
    ok = ix inside {[5'h00:5'h0a], [5'h0f:5'h15], 5'h1b, [5'h1d:5'h1f]};
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_idx = ix;
    cmd_wdata = wd;
    step();
    cmd_valid = 1'b0;
    check("ready", {15'h0000, ready_o}, {15'h0000, !ok});
    while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    if (done_o !== 1'b1 && refused_o !== 1'b1) num_errors++;
    hit_ref = refused_o;
    rd = rdata_o;
    step();
  endtask
  task automatic rd_chk(input string name, input logic [4:0] ix, input logic [15:0] exp);
    cmd(1'b0, ix, 16'h0000);
    check(name, rd, exp);
  endtask
  task automatic hw_reset();
    rst_i = 1'b1;
    repeat (8) step();
    rst_i = 1'b0;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // status word: other bits pass, latched bits in place
  function automatic logic [15:0] st_exp(input logic l, input logic j, input logic f);
    return (status & 16'hffe9) | {11'h000, f, 1'b0, l, j, 1'b0};
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    {fault, jabber, neg_done, cmd_valid, cmd_write} = '0;
    {cmd_idx, cmd_wdata, rsvd, event_v} = '0;
    link_up = 1'b1;
    rst_i = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h5363));
    status = 16'($urandom);
    partner = 16'($urandom);
    foreach (adv[i]) adv[i] = 16'($urandom);
    hw_reset();
    rd_chk("control", 5'h00, 16'h1140);
    rd_chk("advertise", 5'h04, 16'h01e1);
    cmd(1'b1, 5'h02, 16'($urandom));
    cmd(1'b1, 5'h05, 16'($urandom));
    rd_chk("id high", 5'h02, IDH);
    rd_chk("id low", 5'h03, IDL);
    rd_chk("partner", 5'h05, partner);
    // reserved bits forced to zero, mask readable and driven out
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      rsvd = (i == 0) ? 16'h0000 : 16'($urandom);
      cmd(1'b1, 5'h1e, v);
      check("mask out", mask_o, v & ~rsvd);
      rd_chk("mask", 5'h1e, v & ~rsvd);
    end
    rsvd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      if (!(i inside {[0:10], [15:21], 27, [29:31]})) begin
        cmd(1'b0, 5'(i), 16'h0000);
        check("refused", {15'h0000, hit_ref}, 16'h0001);
      end
    end
    // latches: short dips and spikes, then causes gone or held
    cmd(1'b0, 5'h01, 16'h0000);
    rd_chk("status idle", 5'h01, st_exp(1'b1, 1'b0, 1'b0));
    {link_up, fault, jabber} = 3'b011;
    step();
    {link_up, fault, jabber} = 3'b100;
    rd_chk("status latched", 5'h01, st_exp(1'b0, 1'b1, 1'b1));
    rd_chk("status released", 5'h01, st_exp(1'b1, 1'b0, 1'b0));
    jabber = 1'b1;
    rd_chk("jabber", 5'h01, st_exp(1'b1, 1'b1, 1'b0));
    rd_chk("jabber held", 5'h01, st_exp(1'b1, 1'b1, 1'b0));
    jabber = 1'b0;
    step();
    rd_chk("jabber gone", 5'h01, st_exp(1'b1, 1'b0, 1'b0));
    {neg_done, fault} = 2'b11;
    step();
    {neg_done, fault} = 2'b00;
    rd_chk("ind set", 5'h1b, 16'h0003);
    cmd(1'b1, 5'h1b, 16'h0000);
    rd_chk("ind any", 5'h1b, 16'h0002);
    v = 16'($urandom) | 16'h0002;
    cmd(1'b1, 5'h1b, v);
    rd_chk("ind one", 5'h1b, v & 16'hfffc);
    cmd(1'b0, 5'h1d, 16'h0000);
    v = 16'($urandom) | 16'h0001;
    event_v = v;
    step();
    event_v = 16'h0000;
    cmd(1'b1, 5'h1d, 16'h0000);
    rd_chk("flags", 5'h1d, v);
    rd_chk("flags cleared", 5'h1d, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      cmd(1'b1, 5'h14, v);
      rd_chk("adv addr", 5'h14, v);
      rd_chk("adv data", 5'h15, adv[v[3:0]]);
    end
    // duplex cleared against its default so keeping it is visible
    c = 16'($urandom) & 16'h7cc0;
    cmd(1'b1, 5'h00, c);
    check("control out", control_o, c);
    cmd(1'b1, 5'h00, c | 16'h0200);
    check("restart", {15'h0000, saw_restart}, 16'h0001);
    check("restart low", {15'h0000, restart_o}, 16'h0000);
    rd_chk("control back", 5'h00, c);
    cmd(1'b1, 5'h00, 16'h8000);
    check("soft reset", {15'h0000, saw_soft}, 16'h0001);
    repeat (pmr_pkg::SOFT_RESET_CYCLES + 4) step();
    check("soft done", {15'h0000, soft_o}, 16'h0000);
    rd_chk("kept duplex", 5'h00, 16'h1040);
    rd_chk("mask default", 5'h1e, 16'h0000);
    hw_reset();
    rd_chk("hw default", 5'h00, 16'h1140);
    finish_test();
  end
endmodule
